// File: verilog/ddc_pkg.sv
package ddc_pkg;
  // clock rate
  localparam int CLK_MHZ = 200;
  // times in ns (stable clock in us), counts derived (least times round up)
  localparam int T_ACT_TO_RW_NS = 15;
  localparam int T_ACT_TO_ACT_OTHER_NS = 10;
  localparam int T_REFRESH_CYCLE_NS = 70;
  localparam int T_WRITE_RECOVERY_NS = 15;
  localparam int T_ROW_CLOSE_NS = 15;
  localparam int T_MODE_SET_NS = 10;
  localparam int T_REFRESH_AVG_NS = 7800;
  localparam int T_SELF_EXIT_NONREAD_NS = 75;
  localparam int T_ROW_ACTIVE_MIN_NS = 40;
  localparam int T_ROW_ACTIVE_MAX_NS = 70000;
  localparam int T_ROW_CYCLE_NS = 55;
  localparam int T_STABLE_CLOCK_US = 200;
  localparam int WRITE_TO_READ_GAP = 2;
  localparam int SELF_EXIT_READ_CYC = 200;
  localparam int DLL_LOCK_CYC = 200;
  localparam int MAX_POSTED_REFRESH = 8;
  localparam int INIT_REFRESH_COUNT = 2;
  localparam int BURST_CYC = 2;
  function automatic int ns_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int ns_down(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ACT_TO_RW_CYC = ns_up(T_ACT_TO_RW_NS);
  localparam int ACT_TO_ACT_OTHER_CYC = ns_up(T_ACT_TO_ACT_OTHER_NS);
  localparam int REFRESH_CYCLE_CYC = ns_up(T_REFRESH_CYCLE_NS);
  localparam int AUTOCLOSE_WRITE_RECOVERY_CYC = ns_up(T_WRITE_RECOVERY_NS + T_ROW_CLOSE_NS);
  localparam int ROW_CLOSE_DURATION_CYC = ns_up(T_ROW_CLOSE_NS);
  localparam int MODE_SET_CYC = ns_up(T_MODE_SET_NS);
  localparam int REFRESH_INTERVAL_CYC = ns_down(T_REFRESH_AVG_NS);
  localparam int SELF_EXIT_NONREAD_CYC = ns_up(T_SELF_EXIT_NONREAD_NS);
  localparam int ROW_ACTIVE_MIN_CYC = ns_up(T_ROW_ACTIVE_MIN_NS);
  localparam int ROW_ACTIVE_MAX_CYC = ns_down(T_ROW_ACTIVE_MAX_NS);
  localparam int ROW_CYCLE_CYC = ns_up(T_ROW_CYCLE_NS);
  localparam int STABLE_CLOCK_CYC = T_STABLE_CLOCK_US * CLK_MHZ;
  // command encodings {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DDC_CMD_NOP = 4'h7,
    DDC_CMD_ACT = 4'h3,
    DDC_CMD_RD = 4'h5,
    DDC_CMD_WR = 4'h4,
    DDC_CMD_PRE = 4'h2,
    DDC_CMD_REF = 4'h1,
    DDC_CMD_MODE = 4'h0
  } ddc_cmd_t;
  // user request codes
  typedef enum logic [2:0] {
    DDC_REQ_READ = 3'h0,
    DDC_REQ_WRITE = 3'h1,
    DDC_REQ_WRITE_AP = 3'h2,
    DDC_REQ_PRECHARGE = 3'h3,
    DDC_REQ_SELF_ENTER = 3'h4,
    DDC_REQ_SELF_EXIT = 3'h5
  } ddc_req_t;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int DATA_W = 16;
  localparam int AP_BIT = 10;
  localparam int DLL_RESET_BIT = 8;
  localparam logic [ADDR_W-1:0] EXT_MODE_DLL_ON = 13'h0000;
  localparam logic [ADDR_W-1:0] MODE_BASE = 13'h0022;
  localparam logic [BANK_W-1:0] BANK_MODE = 2'h0;
  localparam logic [BANK_W-1:0] BANK_EXT_MODE = 2'h1;
  localparam int TIMER_W = 16;
endpackage

// File: verilog/ddc_timer.sv
`timescale 1ns/1ps
// down counter: load a cycle count, done high once it reaches zero
module ddc_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [ddc_pkg::TIMER_W-1:0] value,
  output logic done
);
  logic [ddc_pkg::TIMER_W-1:0] cnt_reg, cnt_next;

  // count down, hold at zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0) && !load;
endmodule

// File: verilog/ddc_ctrl.sv
`timescale 1ns/1ps
module ddc_ctrl #(
  parameter int STABLE_CYC = ddc_pkg::STABLE_CLOCK_CYC,
  parameter int REFI_CYC = ddc_pkg::REFRESH_INTERVAL_CYC,
  parameter int RAS_MAX_CYC = ddc_pkg::ROW_ACTIVE_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [ddc_pkg::BANK_W-1:0] req_bank,
  input wire logic [ddc_pkg::ADDR_W-1:0] req_row,
  input wire logic [ddc_pkg::ADDR_W-1:0] req_col,
  output logic req_ready,
  output logic init_done,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [ddc_pkg::BANK_W-1:0] mem_ba,
  output logic [ddc_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_dqs_o,
  output logic mem_dqs_oe
);
  typedef enum logic [4:0] {
    S_POWER, S_WAKE, S_PRE1, S_EMODE, S_MODE1, S_PRE2, S_REF, S_MODE2, S_LOCK,
    S_IDLE, S_ACT, S_RW, S_CLOSE, S_REFRESH, S_SELF, S_SELF_WAIT, S_WAIT
  } ddc_state_t;

  ddc_state_t state_reg, state_next, ret_reg, ret_next;
  logic [3:0] cmd_reg, cmd_next;
  logic [ddc_pkg::BANK_W-1:0] ba_reg, ba_next;
  logic [ddc_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic cke_reg, cke_next, ready_reg, ready_next, done_reg, done_next;
  logic dqs_o_reg, dqs_o_next, dqs_oe_reg, dqs_oe_next;
  logic [1:0] inits_reg, inits_next;
  logic [3:0] owed_reg, owed_next;
  logic [ddc_pkg::TIMER_W-1:0] refi_reg, refi_next;
  logic [ddc_pkg::TIMER_W-1:0] ras_reg, ras_next;
  logic [ddc_pkg::TIMER_W-1:0] wtr_reg, wtr_next;
  logic [ddc_pkg::TIMER_W-1:0] xsrd_reg, xsrd_next;
  logic [31:0] stable_reg, stable_next;
  logic [2:0] kind_reg, kind_next;
  logic [ddc_pkg::ADDR_W-1:0] col_reg, col_next;
  logic t_load, t_done;
  logic [ddc_pkg::TIMER_W-1:0] t_value;
  function automatic logic [ddc_pkg::TIMER_W-1:0] cyc(input int n);
    return ddc_pkg::TIMER_W'(n - 1);
  endfunction
  // single wait timer for command spacing
  ddc_timer u_wait (
    .core_clk(core_clk),
    .rst(rst),
    .load(t_load),
    .value(t_value),
    .done(t_done)
  );

  // sequencer: power-up, then request handling with refresh priority
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    cmd_next = ddc_pkg::DDC_CMD_NOP;
    ba_next = ba_reg;
    addr_next = addr_reg;
    cke_next = cke_reg;
    ready_next = 1'b0;
    done_next = done_reg;
    dqs_o_next = 1'b0;
    dqs_oe_next = 1'b0;
    inits_next = inits_reg;
    owed_next = owed_reg;
    stable_next = stable_reg;
    kind_next = kind_reg;
    col_next = col_reg;
    t_load = 1'b0;
    t_value = '0;
    refi_next = (refi_reg == '0) ? cyc(REFI_CYC) : refi_reg - 1'b1;
    if (refi_reg == '0 && done_reg && owed_reg < 4'(ddc_pkg::MAX_POSTED_REFRESH)) begin
      owed_next = owed_reg + 1'b1;
    end
    ras_next = (ras_reg == '0) ? '0 : ras_reg - 1'b1;
    wtr_next = (wtr_reg == '0) ? '0 : wtr_reg - 1'b1;
    xsrd_next = (xsrd_reg == '0) ? '0 : xsrd_reg - 1'b1;
    unique case (state_reg)
      S_POWER: begin
        cke_next = 1'b0;
        if (stable_reg == 32'(STABLE_CYC)) begin
          state_next = S_WAKE;
        end else begin
          stable_next = stable_reg + 1'b1;
        end
      end
      S_WAKE: begin
        cke_next = 1'b1;
        state_next = S_PRE1;
      end
      S_PRE1, S_PRE2: begin
        cmd_next = ddc_pkg::DDC_CMD_PRE;
        addr_next = ddc_pkg::ADDR_W'(1) << ddc_pkg::AP_BIT;
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::ROW_CLOSE_DURATION_CYC);
        ret_next = (state_reg == S_PRE1) ? S_EMODE : S_REF;
        state_next = S_WAIT;
      end
      S_EMODE: begin
        cmd_next = ddc_pkg::DDC_CMD_MODE;
        ba_next = ddc_pkg::BANK_EXT_MODE;
        addr_next = ddc_pkg::EXT_MODE_DLL_ON;
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::MODE_SET_CYC);
        ret_next = S_MODE1;
        state_next = S_WAIT;
      end
      S_MODE1: begin
        cmd_next = ddc_pkg::DDC_CMD_MODE;
        ba_next = ddc_pkg::BANK_MODE;
        addr_next = ddc_pkg::MODE_BASE | (ddc_pkg::ADDR_W'(1) << ddc_pkg::DLL_RESET_BIT);
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::MODE_SET_CYC);
        xsrd_next = cyc(ddc_pkg::DLL_LOCK_CYC); // lock time before any read
        ret_next = S_PRE2;
        state_next = S_WAIT;
      end
      S_REF: begin
        cmd_next = ddc_pkg::DDC_CMD_REF;
        inits_next = inits_reg + 1'b1;
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::REFRESH_CYCLE_CYC);
        ret_next = (inits_reg == 2'(ddc_pkg::INIT_REFRESH_COUNT - 1)) ? S_MODE2 : S_REF;
        state_next = S_WAIT;
      end
      S_MODE2: begin
        cmd_next = ddc_pkg::DDC_CMD_MODE;
        ba_next = ddc_pkg::BANK_MODE;
        addr_next = ddc_pkg::MODE_BASE;
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::MODE_SET_CYC);
        ret_next = S_LOCK;
        state_next = S_WAIT;
      end
      S_LOCK: begin
        if (xsrd_reg == '0) begin
          done_next = 1'b1;
          state_next = S_IDLE;
        end
      end
      S_IDLE: begin
        if (owed_reg != '0) begin
          state_next = S_REFRESH;
        end else if (req_valid && ready_reg) begin
          kind_next = req_kind;
          ba_next = req_bank;
          col_next = req_col;
          addr_next = req_row;
          unique case (req_kind)
            ddc_pkg::DDC_REQ_SELF_ENTER: state_next = S_SELF;
            ddc_pkg::DDC_REQ_PRECHARGE: state_next = S_CLOSE;
            ddc_pkg::DDC_REQ_SELF_EXIT: state_next = S_IDLE;
            default: state_next = S_ACT;
          endcase
        end else begin
          ready_next = (owed_next == '0); // never offer a take that a refresh would steal
        end
      end
      S_ACT: begin
        cmd_next = ddc_pkg::DDC_CMD_ACT;
        ras_next = cyc(ddc_pkg::ROW_ACTIVE_MIN_CYC);
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::ACT_TO_RW_CYC); // exceeds spacing
        ret_next = S_RW;
        state_next = S_WAIT;
      end
      S_RW: begin
        if (kind_reg == ddc_pkg::DDC_REQ_READ && (wtr_reg != '0 || xsrd_reg != '0)) begin
          state_next = S_RW;
        end else begin
          addr_next = col_reg;
          addr_next[ddc_pkg::AP_BIT] = 1'b1;
          if (kind_reg == ddc_pkg::DDC_REQ_READ) begin
            cmd_next = ddc_pkg::DDC_CMD_RD;
            t_value = cyc(ddc_pkg::ROW_CYCLE_CYC);
          end else begin
            cmd_next = ddc_pkg::DDC_CMD_WR;
            dqs_oe_next = 1'b1; // preamble low
            dqs_o_next = 1'b0;
            wtr_next = cyc(ddc_pkg::BURST_CYC + ddc_pkg::WRITE_TO_READ_GAP);
            t_value = cyc(ddc_pkg::BURST_CYC + ddc_pkg::AUTOCLOSE_WRITE_RECOVERY_CYC);
          end
          t_load = 1'b1;
          ret_next = S_IDLE;
          state_next = S_WAIT;
        end
      end
      S_CLOSE: begin
        if (ras_reg == '0) begin
          cmd_next = ddc_pkg::DDC_CMD_PRE;
          addr_next = ddc_pkg::ADDR_W'(1) << ddc_pkg::AP_BIT;
          t_load = 1'b1;
          t_value = cyc(ddc_pkg::ROW_CLOSE_DURATION_CYC);
          ret_next = S_IDLE;
          state_next = S_WAIT;
        end
      end
      S_REFRESH: begin
        cmd_next = ddc_pkg::DDC_CMD_REF;
        owed_next = owed_next - 1'b1;
        t_load = 1'b1;
        t_value = cyc(ddc_pkg::REFRESH_CYCLE_CYC);
        ret_next = S_IDLE;
        state_next = S_WAIT;
      end
      S_SELF: begin
        cmd_next = ddc_pkg::DDC_CMD_REF;
        cke_next = 1'b0;
        owed_next = '0;
        state_next = S_SELF_WAIT;
      end
      S_SELF_WAIT: begin
        ready_next = 1'b1;
        if (req_valid && ready_reg && req_kind == ddc_pkg::DDC_REQ_SELF_EXIT) begin
          ready_next = 1'b0;
          cke_next = 1'b1;
          xsrd_next = cyc(ddc_pkg::SELF_EXIT_READ_CYC);
          t_load = 1'b1;
          t_value = cyc(ddc_pkg::SELF_EXIT_NONREAD_CYC);
          ret_next = S_IDLE;
          state_next = S_WAIT;
        end
      end
      S_WAIT: begin
        if (t_done) begin
          state_next = ret_reg;
        end
      end
    endcase
  end

  // register everything; outputs come from these flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_POWER;
      ret_reg <= S_IDLE;
      cmd_reg <= ddc_pkg::DDC_CMD_NOP;
      ba_reg <= '0;
      addr_reg <= '0;
      cke_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      dqs_o_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
      inits_reg <= '0;
      owed_reg <= '0;
      refi_reg <= '0;
      ras_reg <= '0;
      wtr_reg <= '0;
      xsrd_reg <= '0;
      stable_reg <= '0;
      kind_reg <= '0;
      col_reg <= '0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      cmd_reg <= cmd_next;
      ba_reg <= ba_next;
      addr_reg <= addr_next;
      cke_reg <= cke_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      dqs_o_reg <= dqs_o_next;
      dqs_oe_reg <= dqs_oe_next;
      inits_reg <= inits_next;
      owed_reg <= owed_next;
      refi_reg <= refi_next;
      ras_reg <= ras_next;
      wtr_reg <= wtr_next;
      xsrd_reg <= xsrd_next;
      stable_reg <= stable_next;
      kind_reg <= kind_next;
      col_reg <= col_next;
    end
  end

  assign req_ready = ready_reg;
  assign init_done = done_reg;
  assign mem_cke = cke_reg;
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd_reg;
  assign mem_ba = ba_reg;
  assign mem_addr = addr_reg;
  assign mem_dqs_o = dqs_o_reg;
  assign mem_dqs_oe = dqs_oe_reg;

  // checks on the pin sequence
  a_owed_bound: assert property (@(posedge core_clk) disable iff (rst)
    owed_reg <= 4'(ddc_pkg::MAX_POSTED_REFRESH)) else $error("too many refreshes owed");
  a_act_to_rw: assert property (@(posedge core_clk) disable iff (rst)
    cmd_reg == ddc_pkg::DDC_CMD_ACT |-> ##1 (cmd_reg != ddc_pkg::DDC_CMD_RD
    && cmd_reg != ddc_pkg::DDC_CMD_WR) [*2]) else $error("read or write too soon");
  a_ref_spacing: assert property (@(posedge core_clk) disable iff (rst)
    cmd_reg == ddc_pkg::DDC_CMD_REF && cke_reg |-> ##1 (cmd_reg == ddc_pkg::DDC_CMD_NOP) [*8])
    else $error("command too soon after refresh");
  a_mode_gap: assert property (@(posedge core_clk) disable iff (rst)
    cmd_reg == ddc_pkg::DDC_CMD_MODE |=> cmd_reg == ddc_pkg::DDC_CMD_NOP)
    else $error("command too soon after mode set");
  a_power_cke: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == S_POWER |-> !cke_reg && cmd_reg == ddc_pkg::DDC_CMD_NOP)
    else $error("clock enable high during power up");
  a_cke_stays: assert property (@(posedge core_clk) disable iff (rst)
    done_reg && $rose(cke_reg) |=> cke_reg [*2]) else $error("clock enable dropped");
  a_last_mode: assert property (@(posedge core_clk) disable iff (rst)
    $rose(done_reg) |-> !$past(addr_reg[ddc_pkg::DLL_RESET_BIT]))
    else $error("final mode set with DLL reset");
  a_preamble: assert property (@(posedge core_clk) disable iff (rst)
    cmd_reg == ddc_pkg::DDC_CMD_WR |-> mem_dqs_oe && !mem_dqs_o)
    else $error("no write preamble");
  a_refi_served: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == S_IDLE && owed_reg != '0 |=> state_reg == S_REFRESH)
    else $error("owed refresh not served");
  c_init: cover property (@(posedge core_clk) disable iff (rst) $rose(done_reg));
  c_write: cover property (@(posedge core_clk) disable iff (rst) cmd_reg == ddc_pkg::DDC_CMD_WR);
  c_read: cover property (@(posedge core_clk) disable iff (rst) cmd_reg == ddc_pkg::DDC_CMD_RD);
  c_self: cover property (@(posedge core_clk) disable iff (rst) state_reg == S_SELF_WAIT);
endmodule

// File: sim/ddc_mem_model.sv
`timescale 1ns/1ps
// device side: watches commands and counts spacing or order faults
module ddc_mem_model #(
  parameter int STABLE_CYC = 20,
  parameter int REFI_CYC = 200
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [ddc_pkg::BANK_W-1:0] mem_ba,
  input wire logic [ddc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_dqs_o,
  input wire logic mem_dqs_oe,
  output logic [15:0] viol_cnt,
  output logic [15:0] ref_cnt,
  output logic [15:0] rw_cnt,
  output logic init_seen
);
  logic [3:0] cmd;
  logic in_self, cke_up;
  int cyc, step, t_any, t_ref, t_mode, t_wend, t_exit, t_dll;
  localparam int LONG_AGO = -100000; // far enough back never to limit a command
  int t_act[4];
  int t_wap[4];
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  // count a fault when the condition does not hold
  task automatic need(input logic c);
    if (c !== 1'b1) viol_cnt = viol_cnt + 16'h1;
  endtask
  // command decoder and timing bookkeeping
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      viol_cnt = 16'h0;
      ref_cnt = 16'h0;
      rw_cnt = 16'h0;
      init_seen = 1'b0;
      in_self = 1'b0;
      cke_up = 1'b0;
      cyc = 0;
      step = 0;
      {t_any, t_ref, t_mode, t_wend, t_exit, t_dll} = {6{LONG_AGO}};
      for (int i = 0; i < 4; i++) begin
        t_act[i] = LONG_AGO;
        t_wap[i] = LONG_AGO;
      end
    end else begin
      cyc = cyc + 1;
      if (!mem_cke) begin
        need(cmd == ddc_pkg::DDC_CMD_NOP || (cke_up && cmd == ddc_pkg::DDC_CMD_REF));
        if (cke_up) begin
          need(in_self || cmd == ddc_pkg::DDC_CMD_REF);
          in_self = 1'b1;
        end
      end else if (!cke_up) begin
        need(cyc > STABLE_CYC && cmd == ddc_pkg::DDC_CMD_NOP);
        cke_up = 1'b1;
      end else if (in_self) begin
        need(cmd == ddc_pkg::DDC_CMD_NOP);
        in_self = 1'b0;
        t_exit = cyc;
        t_ref = cyc;
      end else if (cmd != ddc_pkg::DDC_CMD_NOP) begin
        need(cyc - t_mode >= ddc_pkg::MODE_SET_CYC);
        if (cmd != ddc_pkg::DDC_CMD_RD) need(cyc - t_exit >= ddc_pkg::SELF_EXIT_NONREAD_CYC);
        if (!init_seen) begin
          case (step)
            0, 3: need(cmd == ddc_pkg::DDC_CMD_PRE && mem_addr[10]);
            1: need(cmd == ddc_pkg::DDC_CMD_MODE && mem_ba == ddc_pkg::BANK_EXT_MODE
                && !mem_addr[0]);
            2: need(cmd == ddc_pkg::DDC_CMD_MODE && mem_ba == ddc_pkg::BANK_MODE
                && mem_addr[8]);
            default: need(cmd == ddc_pkg::DDC_CMD_REF || (step > 5
                && cmd == ddc_pkg::DDC_CMD_MODE && !mem_addr[8]));
          endcase
          init_seen = step > 5 && cmd == ddc_pkg::DDC_CMD_MODE;
          step = step + 1;
        end
        case (cmd)
          ddc_pkg::DDC_CMD_ACT: begin
            need(cyc - t_any >= ddc_pkg::ACT_TO_ACT_OTHER_CYC);
            need(cyc - t_act[mem_ba] >= ddc_pkg::ROW_CYCLE_CYC);
            need(cyc - t_wap[mem_ba] >= ddc_pkg::AUTOCLOSE_WRITE_RECOVERY_CYC);
            need(cyc - t_ref >= ddc_pkg::REFRESH_CYCLE_CYC);
            t_any = cyc;
            t_act[mem_ba] = cyc;
          end
          ddc_pkg::DDC_CMD_RD: begin
            need(cyc - t_act[mem_ba] >= ddc_pkg::ACT_TO_RW_CYC);
            need(cyc - t_wend >= ddc_pkg::WRITE_TO_READ_GAP);
            need(cyc - t_exit >= ddc_pkg::SELF_EXIT_READ_CYC);
            need(cyc - t_dll >= ddc_pkg::DLL_LOCK_CYC);
            rw_cnt = rw_cnt + 16'h1;
          end
          ddc_pkg::DDC_CMD_WR: begin
            need(cyc - t_act[mem_ba] >= ddc_pkg::ACT_TO_RW_CYC);
            need(mem_dqs_oe && !mem_dqs_o);
            t_wend = cyc + 1 + ddc_pkg::BURST_CYC;
            if (mem_addr[10]) t_wap[mem_ba] = t_wend;
            rw_cnt = rw_cnt + 16'h1;
          end
          ddc_pkg::DDC_CMD_REF: begin
            need(cyc - t_ref >= ddc_pkg::REFRESH_CYCLE_CYC);
            if (init_seen) need(cyc - t_ref <= ddc_pkg::MAX_POSTED_REFRESH * REFI_CYC);
            t_ref = cyc;
            ref_cnt = ref_cnt + 16'h1;
          end
          ddc_pkg::DDC_CMD_MODE: begin
            t_mode = cyc;
            if (mem_ba == ddc_pkg::BANK_MODE && mem_addr[8]) t_dll = cyc;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// File: sim/ddr_command_timing_and_init_tb.sv
`timescale 1ns/1ps
// bench for the command timing and power-up controller
module ddr_command_timing_and_init_tb;
  localparam int STABLE = 20;
  localparam int REFI = 200;
  logic core_clk, rst, req_valid;
  logic [2:0] req_kind;
  logic [ddc_pkg::BANK_W-1:0] req_bank;
  logic [ddc_pkg::ADDR_W-1:0] req_row, req_col, mem_addr;
  logic req_ready, init_done, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [ddc_pkg::BANK_W-1:0] mem_ba;
  logic mem_dqs_o, mem_dqs_oe, init_seen;
  logic [15:0] viol_cnt, ref_cnt, rw_cnt, r0;
  int errors, checked;
  ddc_ctrl #(.STABLE_CYC(STABLE), .REFI_CYC(REFI),
    .RAS_MAX_CYC(ddc_pkg::ROW_ACTIVE_MAX_CYC)) DUT (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_kind(req_kind),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_ready(req_ready),
    .init_done(init_done), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
    .mem_dqs_o(mem_dqs_o), .mem_dqs_oe(mem_dqs_oe));
  ddc_mem_model #(.STABLE_CYC(STABLE), .REFI_CYC(REFI)) mem (
    .core_clk(core_clk), .rst(rst), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .mem_dqs_o(mem_dqs_o), .mem_dqs_oe(mem_dqs_oe),
    .viol_cnt(viol_cnt), .ref_cnt(ref_cnt), .rw_cnt(rw_cnt), .init_seen(init_seen));
  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // 0 ready, 1 init done, 2 clock enable low
  function automatic logic flag(input int which);
    case (which)
      0: return req_ready;
      1: return init_done;
      default: return ~mem_cke;
    endcase
  endfunction
  task automatic wait_until(input int which, input int n);
    int i;
    i = 0;
    while (flag(which) !== 1'b1) begin
      if (i == n) begin
        errors++;
        stop_test();
      end
      @(posedge core_clk);
      #1;
      i++;
    end
  endtask
  task automatic send(input logic [2:0] k, input logic [ddc_pkg::BANK_W-1:0] b);
    wait_until(0, 3000);
    req_kind = k;
    req_bank = b;
    req_row = {11'h029, b};
    req_col = 13'h010;
    req_valid = 1'b1;
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    check({15'h0, req_ready}, 16'h0); // one request at a time
  endtask
  // power-up: clock enable held low, then ordered init
  task automatic do_init();
    repeat (10) @(posedge core_clk);
    #1;
    check({14'h0, mem_cke, init_done}, 16'h0);
    wait_until(1, 3000);
    check({15'h0, init_seen}, 16'h1);
    check(viol_cnt, 16'h0);
  endtask
  // back-to-back accesses over all banks and the read, write and precharge kinds
  task automatic do_access();
    r0 = rw_cnt;
    send(ddc_pkg::DDC_REQ_READ, 2'h0);
    send(ddc_pkg::DDC_REQ_WRITE, 2'h1);
    send(ddc_pkg::DDC_REQ_READ, 2'h1);
    send(ddc_pkg::DDC_REQ_WRITE_AP, 2'h2);
    send(ddc_pkg::DDC_REQ_WRITE_AP, 2'h2);
    send(ddc_pkg::DDC_REQ_READ, 2'h2);
    send(ddc_pkg::DDC_REQ_WRITE, 2'h3);
    send(ddc_pkg::DDC_REQ_PRECHARGE, 2'h3);
    wait_until(0, 3000);
    check(viol_cnt, 16'h0);
    check(rw_cnt - r0, 16'h7);
  endtask
  // idle run: refreshes keep coming
  task automatic do_refresh();
    r0 = ref_cnt;
    repeat (3 * REFI + 50) @(posedge core_clk);
    #1;
    check({15'h0, (ref_cnt - r0) >= 16'h3}, 16'h1);
    check(viol_cnt, 16'h0);
  endtask
  // self refresh entry, exit, then an immediate read
  task automatic do_self();
    r0 = rw_cnt;
    send(ddc_pkg::DDC_REQ_SELF_ENTER, 2'h0);
    wait_until(2, 100);
    repeat (50) @(posedge core_clk);
    #1;
    check({15'h0, mem_cke}, 16'h0);
    send(ddc_pkg::DDC_REQ_SELF_EXIT, 2'h0);
    send(ddc_pkg::DDC_REQ_READ, 2'h1);
    send(ddc_pkg::DDC_REQ_WRITE, 2'h0);
    wait_until(0, 3000);
    check({15'h0, mem_cke}, 16'h1);
    check(viol_cnt, 16'h0);
    check(rw_cnt - r0, 16'h2);
  endtask
  // reset in mid-run, then a fresh power-up
  task automatic do_mid_reset();
    send(ddc_pkg::DDC_REQ_WRITE, 2'h1);
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check({11'h0, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}, 16'h07);
    rst = 1'b0;
    do_init();
    do_access();
  endtask
  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_kind = 3'h0;
    req_bank = 2'h0;
    req_row = 13'h0000;
    req_col = 13'h0000;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    do_init();
    do_access();
    do_refresh();
    do_self();
    do_mid_reset();
    stop_test();
  end
endmodule
